// ---- src/ees_ecc.sv ----
// Single-error-correcting code over one 32-bit word with six check bits
`timescale 1ns/10ps
module ees_ecc import ees_pkg::*; (
  // Encoder
  input wire logic [EES_DATA_W-1:0] enc_data,
  output logic [EES_CHK_W-1:0] enc_check,
  // Decoder
  input wire logic [EES_CW_W-1:0] dec_word,
  output logic [EES_DATA_W-1:0] dec_data
);

  logic [EES_CW_W:1] cw;
  logic [EES_CHK_W-1:0] syn;

  // Data bits fill the non power-of-two code positions
  function automatic logic [EES_CW_W:1] place(input logic [EES_DATA_W-1:0] d);
    int j;
    logic [EES_CW_W:1] c;
    j = 0;
    c = '0;
    for (int p = 1; p <= EES_CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    return c;
  endfunction

  function automatic logic [EES_DATA_W-1:0] extract(input logic [EES_CW_W:1] c);
    int j;
    logic [EES_DATA_W-1:0] d;
    j = 0;
    d = '0;
    for (int p = 1; p <= EES_CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p];
        j++;
      end
    end
    return d;
  endfunction

  function automatic logic [EES_CHK_W-1:0] parity(input logic [EES_CW_W:1] c);
    logic [EES_CHK_W-1:0] k;
    k = '0;
    for (int p = 1; p <= EES_CW_W; p++) begin
      for (int b = 0; b < EES_CHK_W; b++) begin
        if (p[b]) begin
          k[b] = k[b] ^ c[p];
        end
      end
    end
    return k;
  endfunction

  assign enc_check = parity(place(enc_data));

  always_comb begin
    cw = place(dec_word[EES_DATA_W-1:0]);
    syn = parity(cw) ^ dec_word[EES_CW_W-1:EES_DATA_W];
    if (syn != '0 && int'(syn) <= EES_CW_W) begin
      cw[syn] = ~cw[syn];
    end
    dec_data = extract(cw);
  end

endmodule

// ---- src/ees_mem.sv ----
// Word array with check bits, registered read port
`timescale 1ns/10ps
module ees_mem import ees_pkg::*; (
  // Clock
  input wire logic clk,
  // Read port
  input wire ees_mrd_s rd,
  output logic [EES_CW_W-1:0] rd_data,
  // Write port
  input wire ees_mwr_s wr
);

  logic [EES_CW_W-1:0] mem [0:(2**EES_WADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
    if (rd.en) begin
      rd_data <= mem[rd.addr];
    end
  end

endmodule

// ---- src/ees_pkg.sv ----
// Package: constants, states and carrier types of the two-wire memory slave
// Function
// - Start is data falling while clock is high; every transfer begins with one.
// - Watch for start at all times except during programming; ignore bus until start.
// - Stop is data rising while clock is high; it ends the current exchange.
// - A not-acknowledged read byte followed by stop leaves the device in standby.
// - After eight bits the sender releases data; receiver pulls low in ninth slot.
// - Incoming data bits are captured on the clock rising edge.
// - Respond only when the select strap field equals the three strap inputs.
// - Select bit 0 gives direction: one is read, zero is write.
// - Acknowledge a matching select in slot nine; on mismatch release and idle.
// - After a write select, take and acknowledge two address bytes, then data.
// - Protect seen from start to second address byte: ack addresses, refuse data.
// - Byte address is sixteen bits, high byte first, then low byte; only the low fourteen bits (EES_ADDR_W) are kept.
// - After programming the address counter points past the last byte written.
// - While programming, keep data output off and ignore every request.
// - Single byte: ack when writable; with protect high, refuse and keep location.
// - Page write carries up to a row of bytes, all programmed in one cycle.
// - During page write only the in-row address part advances per byte.
// - Each four-byte word carries six check bits; single errors corrected on read.
// - Each completed read byte advances the address counter by one.
// - Sequential read wraps from the last location to zero.
// - Sample the ack after each read byte; high means stop sending and idle.
// - Reads work whatever the protect input level.
package ees_pkg;

  // ==========================================================
  // Array geometry
  localparam int EES_ADDR_W = 14;
  localparam int EES_WADDR_W = EES_ADDR_W - 2;
  localparam int EES_ROW_LSB = 6;
  localparam int EES_DATA_W = 32;
  localparam int EES_CHK_W = 6;
  localparam int EES_CW_W = EES_DATA_W + EES_CHK_W;

  // ==========================================================
  // Synchronised pin positions
  localparam int EES_PIN_W = 6;
  localparam int EES_PIN_SCL = 0;
  localparam int EES_PIN_SDA = 1;
  localparam int EES_PIN_WP = 2;
  localparam int EES_PIN_STRAP = 3;

  // ==========================================================
  // Bit slot counts and timing
  localparam logic [3:0] EES_BYTE_BITS = 4'h8;
  localparam logic [3:0] EES_STOP_SLOT = 4'h1;
  localparam int EES_CLK_PERIOD_NS = 8;
  localparam int EES_PROG_TIME_NS = 5000000;
  localparam int EES_PROG_CYCLES = EES_PROG_TIME_NS / EES_CLK_PERIOD_NS;
  localparam int EES_CNT_W = 20;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    EES_IDLE = 3'h0,
    EES_SEL = 3'h1,
    EES_ADH = 3'h2,
    EES_ADL = 3'h3,
    EES_WDATA = 3'h4,
    EES_RDATA = 3'h5,
    EES_PROG = 3'h6,
    EES_BUSY = 3'h7
  } ees_state_e;

  typedef struct packed {
    logic en;
    logic [EES_WADDR_W-1:0] addr;
    logic [EES_CW_W-1:0] data;
  } ees_mwr_s;

  typedef struct packed {
    logic en;
    logic [EES_WADDR_W-1:0] addr;
  } ees_mrd_s;

endpackage

// ---- src/ees_slave.sv ----
// Two-wire memory slave: bus framing, addressing, page buffer, programming and read path
`timescale 1ns/10ps
module ees_slave import ees_pkg::*; #(
  parameter int unsigned PROG_CYCLES = EES_PROG_CYCLES,
  parameter logic [3:0] DEV_TYPE = 4'h6 // Arbitrary type code
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps and protection
  input wire logic [2:0] strap_address_inputs,
  input wire logic write_protect_input,
  // Status
  output logic prog_busy
);

  localparam int PAGE_BYTES = 2**EES_ROW_LSB;
  localparam int PAGE_WORDS = PAGE_BYTES / 4;
  localparam int WI_W = EES_ROW_LSB - 2;

  typedef struct packed {
    ees_state_e st;
    logic [EES_PIN_W-1:0] sy1;
    logic [EES_PIN_W-1:0] sy2;
    logic [EES_PIN_W-1:0] sy3;
    logic [EES_PIN_W-1:0] filt;
    logic [7:0] sh;
    logic [3:0] bits;
    logic ackph;
    logic rw;
    logic oe;
    logic wp_seen;
    logic got;
    logic [EES_ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] bvalid;
    logic [PAGE_BYTES*8-1:0] pbuf;
    logic [7:0] rdbyte;
    logic fetch;
    logic [WI_W-1:0] widx;
    logic ph;
    logic [EES_CNT_W-1:0] cnt;
  } ees_reg_s;

  ees_reg_s r;
  ees_reg_s next_r;

  logic [EES_PIN_W-1:0] lv;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  logic fetch_go;
  logic prog_rd;
  logic [31:0] mw;
  ees_mrd_s mrd;
  ees_mwr_s mwr;
  logic [EES_CW_W-1:0] mrd_data;
  logic [EES_DATA_W-1:0] fixed;
  logic [EES_CHK_W-1:0] chk;

  // ==========================================================
  // Array and check code
  ees_mem u_mem (
    .clk(clk),
    .rd(mrd),
    .rd_data(mrd_data),
    .wr(mwr)
  );

  ees_ecc u_ecc (
    .enc_data(mw),
    .enc_check(chk),
    .dec_word(mrd_data),
    .dec_data(fixed)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    fetch_go = 1'b0;
    prog_rd = 1'b0;
    mw = fixed;
    mwr = '0;

    // Three-stage capture; a level counts once stages two and three agree
    next_r.sy1 = {strap_address_inputs, write_protect_input, sda_in, scl_in};
    next_r.sy2 = r.sy1;
    next_r.sy3 = r.sy2;
    for (int i = 0; i < EES_PIN_W; i++) begin
      lv[i] = (r.sy2[i] == r.sy3[i]) ? r.sy3[i] : r.filt[i];
    end
    next_r.filt = lv;

    start_ev = r.filt[EES_PIN_SCL] & lv[EES_PIN_SCL] & r.filt[EES_PIN_SDA] & ~lv[EES_PIN_SDA];
    stop_ev = r.filt[EES_PIN_SCL] & lv[EES_PIN_SCL] & ~r.filt[EES_PIN_SDA] & lv[EES_PIN_SDA];
    rise = ~r.filt[EES_PIN_SCL] & lv[EES_PIN_SCL];
    fall = r.filt[EES_PIN_SCL] & ~lv[EES_PIN_SCL];

    // Read byte arrives one cycle after the array read
    if (r.fetch) begin
      next_r.rdbyte = fixed[{r.addr[1:0], 3'h0} +: 8];
    end

    if (r.st == EES_PROG) begin
      // Read-modify-write of each touched word in the row
      if (!r.ph) begin
        if (r.bvalid[{r.widx, 2'h0} +: 4] != 4'h0) begin
          prog_rd = 1'b1;
          next_r.ph = 1'b1;
        end else if (r.widx == WI_W'(PAGE_WORDS - 1)) begin
          next_r.st = EES_BUSY;
        end else begin
          next_r.widx = r.widx + WI_W'(1);
        end
      end else begin
        for (int b = 0; b < 4; b++) begin
          if (r.bvalid[{r.widx, 2'(b)}]) begin
            mw[b*8 +: 8] = r.pbuf[{r.widx, 2'(b), 3'h0} +: 8];
          end
        end
        mwr.en = 1'b1;
        mwr.addr = {r.addr[EES_ADDR_W-1:EES_ROW_LSB], r.widx};
        mwr.data = {chk, mw};
        next_r.ph = 1'b0;
        if (r.widx == WI_W'(PAGE_WORDS - 1)) begin
          next_r.st = EES_BUSY;
        end else begin
          next_r.widx = r.widx + WI_W'(1);
        end
      end
    end else if (r.st == EES_BUSY) begin
      // Bus is ignored until the programming time has run out
      next_r.cnt = r.cnt + EES_CNT_W'(1);
      if (r.cnt == EES_CNT_W'(PROG_CYCLES - 1)) begin
        next_r.st = EES_IDLE;
      end
    end else if (start_ev) begin
      next_r.st = EES_SEL;
      next_r.bits = 4'h0;
      next_r.ackph = 1'b0;
      next_r.oe = 1'b0;
      next_r.wp_seen = lv[EES_PIN_WP];
      next_r.got = 1'b0;
      next_r.bvalid = '0;
    end else if (stop_ev) begin
      next_r.oe = 1'b0;
      next_r.st = EES_IDLE;
      if (r.st == EES_WDATA && !r.ackph && r.bits == EES_STOP_SLOT && r.got && !r.wp_seen) begin
        next_r.st = EES_PROG;
        next_r.widx = '0;
        next_r.ph = 1'b0;
        next_r.cnt = '0;
      end
    end else if (r.st != EES_IDLE) begin
      if (r.st == EES_SEL || r.st == EES_ADH || r.st == EES_ADL) begin
        next_r.wp_seen = r.wp_seen | lv[EES_PIN_WP];
      end
      if (r.st == EES_RDATA) begin
        if (rise && r.ackph) begin
          if (lv[EES_PIN_SDA]) begin
            next_r.st = EES_IDLE;
          end
        end else if (rise) begin
          next_r.bits = r.bits + 4'h1;
        end else if (fall && r.ackph) begin
          next_r.ackph = 1'b0;
          next_r.bits = 4'h0;
          next_r.sh = r.rdbyte;
          next_r.oe = ~r.rdbyte[7];
        end else if (fall && r.bits == EES_BYTE_BITS) begin
          next_r.oe = 1'b0;
          next_r.ackph = 1'b1;
          next_r.addr = r.addr + EES_ADDR_W'(1);
          fetch_go = 1'b1;
        end else if (fall && r.bits != 4'h0) begin
          next_r.sh = {r.sh[6:0], 1'b0};
          next_r.oe = ~r.sh[6];
        end
      end else if (rise && !r.ackph) begin
        next_r.sh = {r.sh[6:0], lv[EES_PIN_SDA]};
        next_r.bits = r.bits + 4'h1;
      end else if (fall && r.ackph) begin
        // End of the acknowledge slot
        next_r.oe = 1'b0;
        next_r.ackph = 1'b0;
        next_r.bits = 4'h0;
        case (r.st)
          EES_SEL: begin
            if (r.rw) begin
              next_r.st = EES_RDATA;
              next_r.sh = r.rdbyte;
              next_r.oe = ~r.rdbyte[7];
            end else begin
              next_r.st = EES_ADH;
            end
          end
          EES_ADH: begin
            next_r.st = EES_ADL;
          end
          default: begin
            next_r.st = EES_WDATA;
          end
        endcase
      end else if (fall && r.bits == EES_BYTE_BITS) begin
        // Byte complete: decide the acknowledge
        case (r.st)
          EES_SEL: begin
            if (r.sh[7:4] == DEV_TYPE && r.sh[3:1] == lv[EES_PIN_STRAP +: 3]) begin
              next_r.oe = 1'b1;
              next_r.ackph = 1'b1;
              next_r.rw = r.sh[0];
              fetch_go = r.sh[0];
            end else begin
              next_r.st = EES_IDLE;
            end
          end
          EES_ADH: begin
            next_r.addr[EES_ADDR_W-1:8] = r.sh[EES_ADDR_W-9:0];
            next_r.oe = 1'b1;
            next_r.ackph = 1'b1;
          end
          EES_ADL: begin
            next_r.addr[7:0] = r.sh;
            next_r.oe = 1'b1;
            next_r.ackph = 1'b1;
          end
          EES_WDATA: begin
            next_r.ackph = 1'b1;
            if (!r.wp_seen) begin
              next_r.oe = 1'b1;
              next_r.got = 1'b1;
              next_r.pbuf[{r.addr[EES_ROW_LSB-1:0], 3'h0} +: 8] = r.sh;
              next_r.bvalid[r.addr[EES_ROW_LSB-1:0]] = 1'b1;
              next_r.addr[EES_ROW_LSB-1:0] = r.addr[EES_ROW_LSB-1:0] + EES_ROW_LSB'(1);
            end
          end
          default: begin
            next_r.st = EES_IDLE;
          end
        endcase
      end
    end

    next_r.fetch = fetch_go;
    mrd.en = fetch_go | prog_rd;
    mrd.addr = (r.st == EES_PROG) ? {r.addr[EES_ADDR_W-1:EES_ROW_LSB], r.widx}
                                  : next_r.addr[EES_ADDR_W-1:2];
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe = r.oe;
  assign prog_busy = (r.st == EES_PROG) || (r.st == EES_BUSY);

endmodule

// ---- tb/ees_master.sv ----
// Bus master model driving the serial clock and data line
`timescale 1ns/10ps
module ees_master (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One slot: data set while clock low, line sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    wt(2);
    sda_drv = b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = sda;
  endtask
  task automatic start();
    scl = 1'b0;
    wt(3);
    sda_drv = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(5);
    sda_drv = 1'b0;
    wt(5);
  endtask
  task automatic stop();
    scl = 1'b0;
    wt(3);
    sda_drv = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(5);
    sda_drv = 1'b1;
    wt(5);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic rx(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(mack, r);
  endtask
endmodule

// ---- tb/ees_slave_checker.sv ----
// Assertion checker for the two-wire memory slave
`timescale 1ns/10ps
module ees_slave_checker import ees_pkg::*; #(
  parameter int unsigned PROG_CYCLES = EES_PROG_CYCLES,
  parameter logic [3:0] DEV_TYPE = 4'h6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps, protection and status
  input wire logic [2:0] strap_address_inputs,
  input wire logic write_protect_input,
  input wire logic prog_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Pin-level frame tracking
  logic scl_q, sda_q, frame, rd, wp_seen, start_p, stop_p, rise_p;
  logic [7:0] rises, stop_age;
  logic [19:0] bcnt;
  assign start_p = scl_in && scl_q && sda_q && !sda_in;
  assign stop_p = scl_in && scl_q && !sda_q && sda_in;
  assign rise_p = scl_in && !scl_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      frame <= 1'b0;
      rd <= 1'b0;
      wp_seen <= 1'b0;
      rises <= 8'h0;
      stop_age <= 8'hFF;
      bcnt <= 20'h0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      bcnt <= prog_busy ? bcnt + 20'h1 : 20'h0;
      stop_age <= stop_p ? 8'h1 : (stop_age == 8'hFF ? stop_age : stop_age + 8'h1);
      if (start_p) begin
        frame <= 1'b1;
        rises <= 8'h0;
        rd <= 1'b0;
        wp_seen <= write_protect_input;
      end else begin
        if (stop_p) frame <= 1'b0;
        if (rise_p && rises != 8'hFF) rises <= rises + 8'h1;
        if (rise_p && rises == 8'h7) rd <= sda_in;
        if (write_protect_input && rises <= 8'h1A) wp_seen <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Assertions
  chk_out_low: assert property (sda_out == 1'b0)
    else $error("data output value not low");
  chk_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("data pulled while programming");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pull changed with clock high");
  chk_busy_len: assert property ((!prog_busy && bcnt != 20'h0) |->
    (bcnt >= PROG_CYCLES && bcnt <= PROG_CYCLES + 100)) else $error("busy period length wrong");
  chk_prog_stop: assert property ($rose(prog_busy) |-> stop_age <= 8'h8)
    else $error("programming without stop");
  chk_stop_release: assert property (stop_age <= 8'h8 |-> !sda_oe)
    else $error("data pulled after stop");
  chk_frame_only: assert property (sda_oe |-> frame)
    else $error("data pulled outside a frame");
  chk_wp_block: assert property ($rose(prog_busy) |-> !wp_seen)
    else $error("programming under protect");
  chk_ack_slot: assert property (($rose(sda_oe) && !rd) |-> (rises % 8'h9) == 8'h8)
    else $error("write ack outside ninth slot");
endmodule

bind ees_slave ees_slave_checker #(.PROG_CYCLES(PROG_CYCLES), .DEV_TYPE(DEV_TYPE)) u_ees_slave_checker (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .strap_address_inputs(strap_address_inputs), .write_protect_input(write_protect_input), .prog_busy(prog_busy));

// ---- tb/ees_slave_test.sv ----
// Self-checking bench of the two-wire memory slave
`timescale 1ns/10ps
module ees_slave_test;
  localparam int unsigned PC = 200;
  localparam logic [3:0] DT = 4'h6; // Arbitrary type code
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_drv, sda_oe, sda_out, prog_busy, sda;
  int n_mismatch = 0;
  int n_checks = 0;
  assign sda = sda_drv & ~sda_oe;
  always #4 clk = ~clk;
  ees_slave #(.PROG_CYCLES(PC), .DEV_TYPE(DT)) u_ees_slave (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_address_inputs(strap), .write_protect_input(wp),
    .prog_busy(prog_busy));
  ees_master u_ees_master (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // ==========================================================
  // Reporting and helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 2000 && prog_busy !== 1'b0; i++) @(negedge clk);
    if (i == 2000) begin
      n_mismatch++;
      $display("MISMATCH busy wait expected 0 seen 1");
      stop_test();
    end
  endtask
  task automatic prog_chk(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk);
      seen |= prog_busy;
    end
    chk_bit("prog start", e, seen);
    idle();
  endtask
  task automatic sel(input logic [2:0] a, input logic rw, input logic e);
    logic k;
    u_ees_master.start();
    u_ees_master.tx({DT, a, rw}, k);
    chk_bit("select ack", e, k);
  endtask
  task automatic addr(input logic [15:0] a);
    logic k;
    sel(strap, 1'b0, 1'b0);
    u_ees_master.tx(a[15:8], k);
    chk_bit("addr hi ack", 1'b0, k);
    u_ees_master.tx(a[7:0], k);
    chk_bit("addr lo ack", 1'b0, k);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] q[$], input logic nack, input logic prog);
    logic k;
    addr(a);
    foreach (q[i]) begin
      u_ees_master.tx(q[i], k);
      chk_bit("data ack", nack, k);
    end
    u_ees_master.stop();
    prog_chk(prog);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] q[$]);
    logic [7:0] d;
    addr(a);
    sel(strap, 1'b1, 1'b0);
    foreach (q[i]) begin
      u_ees_master.rx(i == q.size() - 1, d);
      chk_byte("read data", q[i], d);
    end
    u_ees_master.stop();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_strap();
    logic k;
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      sel(3'h5, 1'b0, s != 5);
      u_ees_master.stop();
    end
    u_ees_master.start();
    u_ees_master.tx({~DT, strap, 1'b0}, k);
    chk_bit("type ack", 1'b1, k);
    u_ees_master.stop();
  endtask
  task automatic t_write_read();
    logic [7:0] d;
    wr(16'h0102, '{8'h5A}, 1'b0, 1'b1);
    wr(16'h013E, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b0, 1'b1);
    sel(strap, 1'b1, 1'b0);
    u_ees_master.rx(1'b1, d);
    chk_byte("current read", 8'h5A, d);
    u_ees_master.stop();
    rd(16'h013E, '{8'h11, 8'h22});
    rd(16'h0100, '{8'h33, 8'h44, 8'h5A});
    wr(16'h3FFF, '{8'hC3}, 1'b0, 1'b1);
    wr(16'h0000, '{8'h3C}, 1'b0, 1'b1);
    rd(16'h3FFF, '{8'hC3, 8'h3C});
  endtask
  task automatic t_protect();
    wp = 1'b1;
    wr(16'h0102, '{8'h99, 8'h98}, 1'b1, 1'b0);
    rd(16'h0102, '{8'h5A});
    wp = 1'b0;
  endtask
  task automatic t_bad_stop();
    logic k;
    addr(16'h0102);
    u_ees_master.tx(8'h77, k);
    chk_bit("data ack", 1'b0, k);
    repeat (3) u_ees_master.bit_x(1'b0, k);
    u_ees_master.stop();
    prog_chk(1'b0);
    addr(16'h0102);
    u_ees_master.stop();
    prog_chk(1'b0);
    rd(16'h0102, '{8'h5A});
  endtask
  task automatic t_busy();
    logic k;
    addr(16'h0104);
    u_ees_master.tx(8'h66, k);
    chk_bit("data ack", 1'b0, k);
    u_ees_master.stop();
    sel(strap, 1'b0, 1'b1);
    u_ees_master.stop();
    idle();
    sel(strap, 1'b0, 1'b0);
    u_ees_master.stop();
    rd(16'h0104, '{8'h66});
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    t_strap();
    t_write_read();
    t_protect();
    t_bad_stop();
    t_busy();
    stop_test();
  end
endmodule
